// ### inc/imt_pkg.sv
// How it works
// - a buffer write sets buffer-full and starts the baud generator
// - each bit is driven after SCL is pulled low, low for one rollover
// - SDA is set before SCL release, SCL high one period, SDA held
// - at the eighth falling edge buffer-full clears and SDA is released
// - ninth rising edge captures SDA into the acknowledge status bit
// - after a data byte's ninth clock: interrupt flag, generator stops, SCL low
// - address phase sends seven address bits then read/write, msb first
// - after address ninth clock: flag set, buffer-full clear, SCL low held
// - buffer-full is set by a buffer write, cleared after eight bits
// - a buffer write during shifting sets write-collision and is dropped
// - start-enable makes a Start condition, flag set when it completes
// - the start hold time passes before the first address bit
// - shifting begins as soon as the buffer is written after Start
// - every further byte: shift, capture acknowledge, flag after ninth clock
// - stop-enable or restart-enable makes that condition, flag when done
package imt_pkg;
   localparam int           ADDR_W       = 4;
   localparam int           DATA_W       = 8;
   localparam logic [3:0]   ADDR_TXBUF   = 4'h0;
   localparam logic [3:0]   ADDR_CTRL    = 4'h4;
   localparam logic [3:0]   ADDR_STAT    = 4'h8;
   localparam logic [3:0]   ADDR_BAUD    = 4'hC;
   localparam int           CTRL_START   = 0;
   localparam int           CTRL_RESTART = 1;
   localparam int           CTRL_STOP    = 2;
   localparam int           STAT_WRITE_COLLISION_FLAG    = 1;
   localparam int           STAT_IRQ     = 2;
   localparam logic [7:0]   BAUD_RESET   = 8'h18;
   localparam logic [3:0]   BIT_LAST     = 4'h7;
   localparam logic [3:0]   BIT_ACK      = 4'h8;
   localparam logic [1:0]   STEP_LAST    = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_START   = 3'b001,
      ST_HOLD    = 3'b010,
      ST_LOW     = 3'b011,
      ST_HIGH    = 3'b100,
      ST_STOP    = 3'b101,
      ST_RESTART = 3'b110
   } imt_state_e;

   typedef struct packed {
      logic                wr;
      logic                rd;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wdata;
   } imt_req_s;

   typedef struct packed {
      logic   busy;
      logic   ack;
      logic   irq;
      logic   write_collision_flag;
      logic   bf;
   } imt_status_s;
endpackage

// ### design/imt_master_tx.sv
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module imt_master_tx #(
   parameter logic [7:0] BAUD_DEFAULT = imt_pkg::BAUD_RESET
) (
   input  wire logic                       mclk,
   input  wire logic                       resetn,
   input  wire imt_pkg::imt_req_s          reg_req,
   output logic [imt_pkg::DATA_W-1:0]      reg_rdata,
   input  wire logic                       scl_in,
   output logic                            scl_out,
   output logic                            scl_oe,
   input  wire logic                       sda_in,
   output logic                            sda_out,
   output logic                            sda_oe
);
   import imt_pkg::*;

   imt_state_e    state;
   imt_state_e    next_state;
   logic [1:0]    step;
   logic [1:0]    next_step;
   logic [3:0]    bitc;
   logic [3:0]    next_bitc;
   logic [7:0]    tx_buffer;
   logic [7:0]    next_tx_buffer;
   logic [7:0]    shift_register;
   logic [7:0]    next_shift_register;
   logic [2:0]    ctrl;
   logic [2:0]    next_ctrl;
   imt_status_s   st;
   imt_status_s   next_st;
   logic [7:0]    reload;
   logic [7:0]    next_reload;
   logic [7:0]    brg;
   logic [7:0]    next_brg;
   logic [7:0]    next_reg_rdata;
   logic          next_scl_oe;
   logic          next_sda_oe;
   logic [2:0]    scl_sync;
   logic [2:0]    sda_sync;
   logic          scl_f;
   logic          sda_f;
   logic          scl_fd;
   logic          next_scl_f;
   logic          next_sda_f;
   logic          run;
   logic          stretch;
   logic          tick;
   logic          tx_wr;
   logic          scl_rise;

   // open-drain pins: only ever pull low
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;

   // a line change is believed only once the last two stages agree
   always_comb begin
      next_scl_f = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_f;
      next_sda_f = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_f;
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         scl_sync <= 3'h7;
         sda_sync <= 3'h7;
         scl_f    <= 1'b1;
         sda_f    <= 1'b1;
         scl_fd   <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[1:0], scl_in};
         sda_sync <= {sda_sync[1:0], sda_in};
         scl_f    <= next_scl_f;
         sda_f    <= next_sda_f;
         scl_fd   <= scl_f;
      end
   end

   assign scl_rise = scl_f && !scl_fd;
   // a slave holding SCL low stretches the high phase instead of shortening it
   assign stretch  = !scl_f && ((state == ST_HIGH) ||
                     ((state == ST_STOP || state == ST_RESTART) && step == 2'h1));
   assign run      = !(state == ST_IDLE || state == ST_HOLD) && !stretch;
   assign tick     = run && (brg == 8'h00);
   assign tx_wr    = reg_req.wr && (reg_req.addr == ADDR_TXBUF);

   always_comb begin
      next_brg = (!run || brg == 8'h00) ? reload : brg - 8'h01;
   end

   always_comb begin
      next_state          = state;
      next_step           = step;
      next_bitc           = bitc;
      next_tx_buffer      = tx_buffer;
      next_shift_register = shift_register;
      next_ctrl           = ctrl;
      next_st             = st;
      next_reload         = reload;
      next_reg_rdata      = 8'h00;

      // software clears its flags by writing ones; hardware sets below win
      // collision and interrupt clear by software
      if (reg_req.wr && reg_req.addr == ADDR_STAT) begin
         if (reg_req.wdata[STAT_WRITE_COLLISION_FLAG]) next_st.write_collision_flag = 1'b0;
         if (reg_req.wdata[STAT_IRQ]) next_st.irq = 1'b0;
      end
      if (reg_req.wr && reg_req.addr == ADDR_BAUD) next_reload = reg_req.wdata;
      if (reg_req.wr && reg_req.addr == ADDR_CTRL) begin
         // requests are only taken where the bus condition makes sense
         if (state == ST_IDLE && reg_req.wdata[CTRL_START]) next_ctrl[CTRL_START] = 1'b1;
         if (state == ST_HOLD) begin
            next_ctrl[CTRL_STOP]    = ctrl[CTRL_STOP] | reg_req.wdata[CTRL_STOP];
            next_ctrl[CTRL_RESTART] = ctrl[CTRL_RESTART] | reg_req.wdata[CTRL_RESTART];
         end
      end

      unique case (state)
         ST_IDLE: begin
            if (ctrl[CTRL_START]) begin
               next_state = ST_START;
               next_step  = 2'h0;
            end
         end
         ST_START: begin
            if (tick) begin
               // second period is the start hold
               if (step == 2'h0) begin
                  next_step = 2'h1;
               end else begin
                  next_state             = ST_HOLD;
                  next_st.irq            = 1'b1;
                  next_ctrl[CTRL_START]  = 1'b0;
               end
            end
         end
         ST_HOLD: begin
            if (ctrl[CTRL_STOP]) begin
               next_state = ST_STOP;
               next_step  = 2'h0;
            end else if (ctrl[CTRL_RESTART]) begin
               next_state = ST_RESTART;
               next_step  = 2'h0;
            end
         end
         ST_LOW: begin
            if (tick) next_state = ST_HIGH;
         end
         ST_HIGH: begin
            if (bitc == BIT_ACK && scl_rise) next_st.ack = sda_f;
            if (tick) begin
               // every byte ends the same way
               if (bitc == BIT_ACK) begin
                  next_state  = ST_HOLD;
                  next_st.irq = 1'b1;
               end else begin
                  next_state          = ST_LOW;
                  next_bitc           = bitc + 4'h1;
                  next_shift_register = {shift_register[6:0], 1'b0};
                  if (bitc == BIT_LAST) next_st.bf = 1'b0;
               end
            end
         end
         ST_STOP, ST_RESTART: begin
            if (tick) begin
               if (step == STEP_LAST) begin
                  next_state  = (state == ST_STOP) ? ST_IDLE : ST_HOLD;
                  next_st.irq = 1'b1;
                  next_ctrl[CTRL_STOP]    = (state == ST_STOP) ? 1'b0 : ctrl[CTRL_STOP];
                  next_ctrl[CTRL_RESTART] = (state == ST_RESTART) ? 1'b0 : ctrl[CTRL_RESTART];
               end else begin
                  next_step = step + 2'h1;
               end
            end
         end
         default: next_state = ST_IDLE;
      endcase

      if (tx_wr) begin
         if (state == ST_HOLD) begin
            next_tx_buffer      = reg_req.wdata;
            next_shift_register = reg_req.wdata;
            next_st.bf          = 1'b1;
            next_bitc           = 4'h0;
            next_state          = ST_LOW;
         end else begin
            next_st.write_collision_flag = 1'b1;
         end
      end
      next_st.busy = (next_state != ST_IDLE);

      if (reg_req.rd) begin
         unique case (reg_req.addr)
            ADDR_TXBUF: next_reg_rdata = tx_buffer;
            ADDR_CTRL:  next_reg_rdata = {5'h00, ctrl};
            ADDR_STAT:  next_reg_rdata = {3'h0, st};
            ADDR_BAUD:  next_reg_rdata = reload;
            default:    next_reg_rdata = 8'h00;
         endcase
      end
   end

   // pin drive follows the next state so it comes straight from flip-flops
   always_comb begin
      next_scl_oe = 1'b0;
      next_sda_oe = 1'b0;
      unique case (next_state)
         ST_IDLE: ;
         ST_START: next_sda_oe = (next_step != 2'h0);
         ST_HOLD: begin
            // SDA left as it was, so leaving a Start cannot look like a Stop
            next_scl_oe = 1'b1;
            next_sda_oe = sda_oe;
         end
         ST_LOW, ST_HIGH: begin
            // bit set while SCL low, held across the high phase
            next_scl_oe = (next_state == ST_LOW);
            next_sda_oe = (next_bitc < BIT_ACK) && !next_shift_register[7];
         end
         ST_STOP: begin
            next_scl_oe = (next_step == 2'h0);
            next_sda_oe = (next_step != STEP_LAST);
         end
         ST_RESTART: begin
            next_scl_oe = (next_step == 2'h0);
            next_sda_oe = (next_step == STEP_LAST);
         end
         default: ;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         state          <= ST_IDLE;
         step           <= 2'h0;
         bitc           <= 4'h0;
         tx_buffer      <= 8'h00;
         shift_register <= 8'h00;
         ctrl           <= 3'h0;
         st             <= '0;
         reload         <= BAUD_DEFAULT;
         brg            <= BAUD_DEFAULT;
         reg_rdata      <= 8'h00;
         scl_oe         <= 1'b0;
         sda_oe         <= 1'b0;
      end else begin
         state          <= next_state;
         step           <= next_step;
         bitc           <= next_bitc;
         tx_buffer      <= next_tx_buffer;
         shift_register <= next_shift_register;
         ctrl           <= next_ctrl;
         st             <= next_st;
         reload         <= next_reload;
         brg            <= next_brg;
         reg_rdata      <= next_reg_rdata;
         scl_oe         <= next_scl_oe;
         sda_oe         <= next_sda_oe;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   a_wr_sets_bf: assert property (tx_wr && state == ST_HOLD |=> st.bf && state == ST_LOW)
      else $error("buffer write did not set full flag and start shifting");
   a_brg_reload: assert property (tick |=> brg == $past(reload))
      else $error("baud generator did not reload after rollover");
   a_low_holds_scl: assert property (state == ST_LOW && !tick |=> scl_oe)
      else $error("SCL released before the low period ended");
   a_sda_stable_high: assert property (state == ST_HIGH ##1 state == ST_HIGH |-> $stable(sda_oe))
      else $error("SDA moved while SCL high");
   a_bf_clear_eight: assert property (state == ST_HIGH && tick && bitc == BIT_LAST |=> !st.bf && !sda_oe)
      else $error("full flag or SDA not released after eighth clock");
   a_ack_capture: assert property (state == ST_HIGH && bitc == BIT_ACK && scl_rise |=> st.ack == $past(sda_f))
      else $error("acknowledge not captured on ninth rising edge");
   a_ninth_irq: assert property (state == ST_HIGH && tick && bitc == BIT_ACK |=> st.irq && state == ST_HOLD ##1 scl_oe)
      else $error("no flag or SCL not held after ninth clock");
   a_msb_first: assert property (state == ST_LOW && bitc < BIT_ACK |-> sda_oe == !shift_register[7])
      else $error("SDA does not show the current bit");
   a_hold_parks: assert property (state == ST_HOLD && $past(state) == ST_HOLD |-> scl_oe && $stable(sda_oe) && !run)
      else $error("bus not parked while waiting for software");
   a_write_collision_flag_drop: assert property (tx_wr && state != ST_HOLD |=> st.write_collision_flag && $stable(tx_buffer))
      else $error("collision not flagged or buffer changed");
   a_start_hold: assert property (state == ST_START && step == 2'h1 |-> sda_oe && !scl_oe)
      else $error("start hold not kept");
   a_stop_done: assert property (state == ST_STOP && tick && step == STEP_LAST |=> state == ST_IDLE && st.irq && !scl_oe && !sda_oe)
      else $error("stop completion wrong");

   c_start: cover property (state == ST_START ##1 state == ST_HOLD);
   c_byte_nack: cover property (state == ST_HIGH && bitc == BIT_ACK && scl_rise && sda_f);
   c_collision: cover property (tx_wr && state == ST_LOW);
   c_restart: cover property (state == ST_RESTART ##1 state == ST_HOLD);
endmodule
`default_nettype wire

// ### tb/imt_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module imt_slave_model (
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       ack_en,
   input  wire logic       stretch,
   output logic            scl_oe,
   output logic            sda_oe,
   output logic [7:0]      rx_byte
);
   logic [7:0] shift;
   logic [3:0] n_bits;
   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
      rx_byte = 8'h00;
      shift = 8'h00;
      n_bits = 4'h0;
   end
   // start or restart seen: a new frame begins
   always @(negedge sda) begin
      if (scl === 1'b1) begin
         n_bits = 4'h0;
      end
   end
   always @(posedge scl) begin
      if (n_bits < 4'h8) begin
         shift = {shift[6:0], sda};
      end
      n_bits = n_bits + 4'h1;
      if (n_bits == 4'h8) begin
         rx_byte = shift;
      end
   end
   always @(negedge scl) begin
      sda_oe = (n_bits == 4'h8) ? ack_en : 1'b0;
      if (n_bits == 4'h9) begin
         n_bits = 4'h0;
      end
      // a slow slave holds the clock low after each fall
      if (stretch) begin
         scl_oe = 1'b1;
         #400;
         scl_oe = 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import imt_pkg::*;
   logic          mclk;
   logic          resetn;
   imt_req_s      req;
   logic [7:0]    rdata;
   logic          scl_oe;
   logic          sda_oe;
   logic          scl_drv;
   logic          sda_drv;
   logic          s_scl_oe;
   logic          s_sda_oe;
   logic          ack_en;
   logic          stretch;
   logic [7:0]    rx_byte;
   logic          in_byte;
   logic          prev_scl;
   logic          prev_sda;
   int            fails;
   int            n_compared;
   wire logic     scl_w = ~(scl_oe | s_scl_oe);
   wire logic     sda_w = ~(sda_oe | s_sda_oe);

   imt_master_tx i_imt_master_tx (
      .mclk      (mclk),
      .resetn    (resetn),
      .reg_req   (req),
      .reg_rdata (rdata),
      .scl_in    (scl_w),
      .scl_out   (scl_drv),
      .scl_oe    (scl_oe),
      .sda_in    (sda_w),
      .sda_out   (sda_drv),
      .sda_oe    (sda_oe)
   );
   imt_slave_model i_imt_slave_model (
      .scl     (scl_w),
      .sda     (sda_w),
      .ack_en  (ack_en),
      .stretch (stretch),
      .scl_oe  (s_scl_oe),
      .sda_oe  (s_sda_oe),
      .rx_byte (rx_byte)
   );

   initial mclk = 1'b0;
   always #10 mclk = ~mclk;

   // sda may only move while scl is low
   always @(posedge mclk) begin
      if (in_byte && scl_w && prev_scl && sda_w !== prev_sda) begin
         fails++;
         $display("mismatch sda_stable expected %b seen %b", prev_sda, sda_w);
      end
      prev_scl <= scl_w;
      prev_sda <= sda_w;
   end

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk);
      req <= '0;
   endtask

   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge mclk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge mclk);
      req <= '0;
      @(negedge mclk);
      d = rdata;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] m,
                         input logic [7:0] exp, input string name);
      logic [7:0] d;
      rd_reg(a, d);
      chk(name, exp, d & m);
   endtask

   task automatic wait_irq();
      logic [7:0] st;
      int i;
      st = 8'h00;
      for (i = 0; i < 400 && st[STAT_IRQ] !== 1'b1; i++) begin
         rd_reg(ADDR_STAT, st);
      end
      if (st[STAT_IRQ] !== 1'b1) begin
         fails++;
         $display("mismatch irq_wait expected 1 seen %b", st[STAT_IRQ]);
         print_verdict();
      end
   endtask

   // byte with a late buffer write during shifting
   task automatic send_byte(input logic [7:0] d, input logic ack);
      ack_en = ack;
      in_byte = 1'b1;
      wr_reg(ADDR_TXBUF, d);
      rd_chk(ADDR_STAT, 8'h11, 8'h11, "busy_bf");
      wr_reg(ADDR_TXBUF, ~d);
      wait_irq();
      in_byte = 1'b0;
      chk("slave_byte", d, rx_byte);
      rd_chk(ADDR_STAT, 8'h0F, ack ? 8'h06 : 8'h0E, "byte_status");
      rd_chk(ADDR_TXBUF, 8'hFF, d, "buffer_kept");
      chk("wait_pins", 8'h02, {6'h00, scl_oe, sda_oe});
      wr_reg(ADDR_STAT, 8'h06);
      $display("test byte %h done", d);
   endtask

   initial begin
      resetn = 1'b0;
      req = '0;
      ack_en = 1'b1;
      stretch = 1'b0;
      in_byte = 1'b0;
      fails = 0;
      n_compared = 0;
      repeat (12) @(posedge mclk);
      resetn <= 1'b1;
      rd_chk(ADDR_STAT, 8'hFF, 8'h00, "status_reset");
      rd_chk(ADDR_BAUD, 8'hFF, BAUD_RESET, "baud_reset");
      rd_chk(4'h2, 8'hFF, 8'h00, "unmapped");
      chk("pin_levels", 8'h00, {6'h00, scl_drv, sda_drv});
      wr_reg(4'h6, 8'hA5);
      wr_reg(ADDR_TXBUF, 8'h11);
      rd_chk(ADDR_STAT, 8'hFF, 8'h02, "idle_collision");
      wr_reg(ADDR_STAT, 8'h02);
      rd_chk(ADDR_STAT, 8'hFF, 8'h00, "write_collision_flag_cleared");
      wr_reg(ADDR_BAUD, 8'h03);
      rd_chk(ADDR_BAUD, 8'hFF, 8'h03, "baud");
      $display("test registers done");
      wr_reg(ADDR_CTRL, 8'h01);
      wait_irq();
      rd_chk(ADDR_CTRL, 8'h07, 8'h00, "start_done");
      wr_reg(ADDR_STAT, 8'h04);
      $display("test start done");
      send_byte(8'hA4, 1'b1);
      stretch = 1'b1;
      send_byte(8'h5B, 1'b0);
      stretch = 1'b0;
      wr_reg(ADDR_CTRL, 8'h02);
      wait_irq();
      chk("restart_pins", 8'h03, {6'h00, scl_oe, sda_oe});
      wr_reg(ADDR_STAT, 8'h04);
      send_byte(8'hC3, 1'b1);
      wr_reg(ADDR_CTRL, 8'h04);
      wait_irq();
      chk("stop_lines", 8'h03, {6'h00, scl_w, sda_w});
      rd_chk(ADDR_CTRL, 8'h07, 8'h00, "stop_done");
      $display("test stop done");
      print_verdict();
   end
endmodule
`default_nettype wire
